// ==== rtl/addr_filter_pkg.sv ====
// Purpose: shared constants and types for the multidrop receive filter
// Assumes: 8-bit address, 100 MHz system clock
// Notes: register map of the plain register port lives here
package addr_filter_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // register indexes
   localparam logic [3:0] REG_CTRL = 4'h0;   // bit0 multiproc_enable, bits2:1 frame mode
   localparam logic [3:0] REG_SLAVE_ADDRESS = 4'h1;  // slave_address
   localparam logic [3:0] REG_SMASK = 4'h2;  // slave_address_mask
   localparam logic [3:0] REG_STAT = 4'h3;   // read-only event status
   localparam logic [3:0] REG_CLR = 4'h4;    // write-one-to-clear status
   localparam logic [3:0] REG_IEN = 4'h5;    // interrupt enable
   localparam logic [3:0] REG_RXDATA = 4'h6; // last accepted byte, eight data bits only
   // control field positions
   localparam int CTRL_MPE = 0;
   localparam int CTRL_MODE_LO = 1;
   localparam int CTRL_MODE_HI = 2;
   // status bit positions
   localparam int ST_RX = 0;    // receive_flag
   localparam int ST_FE = 1;    // framing_error_flag
   localparam int ST_DROP = 2;  // frame suppressed by filter
   localparam int ST_W = 3;
   localparam logic [7:0] SLAVE_ADDRESS_RST = 8'h00;
   localparam logic [7:0] SMASK_RST = 8'h00;
   localparam logic [2:0] CTRL_RST = 3'h0;
   typedef enum logic [1:0] {MODE0, MODE1, MODE2, MODE3} frame_mode_t;
endpackage : addr_filter_pkg

// ==== rtl/addr_match_if.sv ====
// Purpose: carries a received byte and node addresses to the comparator
// Assumes: single clock, comparator answers combinationally
// Notes: used between the filter top and its compare unit
`timescale 1ns/100ps
interface addr_match_if;
   logic [7:0] rx_byte;
   logic [7:0] slave_address;
   logic [7:0] slave_address_mask;
   logic given_hit;
   logic bcast_hit;
   modport top (output rx_byte, output slave_address, output slave_address_mask,
      input given_hit, input bcast_hit);
   modport cmp (input rx_byte, input slave_address, input slave_address_mask,
      output given_hit, output bcast_hit);
endinterface : addr_match_if

// ==== rtl/addr_compare.sv ====
// Purpose: given and broadcast address comparison
// Assumes: pure combinational, inputs stable in the evaluation cycle
// Notes: mask zero bits are don't-care in the given comparison; broadcast needs ones wherever address or mask is one
`timescale 1ns/100ps
module addr_compare (
   addr_match_if.cmp m
);
   // given: masked bits must equal slave address
   assign m.given_hit = ((m.rx_byte ^ m.slave_address) & m.slave_address_mask) == 8'h00;
   // broadcast: ones of (addr|mask) must be ones in the byte
   wire [7:0] bcast_addr = m.slave_address | m.slave_address_mask;
   assign m.bcast_hit = (m.rx_byte & bcast_addr) == bcast_addr;
endmodule : addr_compare

// ==== rtl/uart_multidrop_address_filter.sv ====
// Purpose: receive-side multidrop address filter of a serial port
// Assumes: deframer hands a finished frame as a one-cycle strobe with data, ninth bit, stop bit
// Notes: register port has read data one cycle after the read strobe
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps
module uart_multidrop_address_filter #(
   parameter int DW = addr_filter_pkg::DATA_W
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic [addr_filter_pkg::ADDR_W-1:0] ADDR,
   input wire logic [DW-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DW-1:0] RDATA,
   input wire logic BIT9_VALID,
   input wire logic [DW-1:0] FRAME_DATA,
   input wire logic FRAME_BIT9,
   input wire logic FRAME_DONE,
   input wire logic FRAME_STOP_OK,
   output logic RX_ACCEPT,
   output logic [DW-1:0] RX_BYTE,
   output logic NINTH_RX_BIT,
   output logic MULTIPROC_ENABLE,
   output logic IRQ
);
   localparam int CW = addr_filter_pkg::CTRL_MODE_HI + 1; // enable bit and two mode bits
   logic [CW-1:0] ctrl_r;
   logic [DW-1:0] slave_address_r;
   logic [DW-1:0] smask_r;
   logic [addr_filter_pkg::ST_W-1:0] stat_r, stat_nxt;
   logic [addr_filter_pkg::ST_W-1:0] ien_r;
   logic [DW-1:0] rdata_r, rdata_nxt;
   logic accept_r, ninth_r, irq_r;
   logic [DW-1:0] rxbyte_r;
   addr_filter_pkg::frame_mode_t mode;
   addr_match_if m ();

   // one decoder for every write keeps the index compare in one place
   function automatic logic wr_sel(input logic strobe,
      input logic [addr_filter_pkg::ADDR_W-1:0] a,
      input logic [addr_filter_pkg::ADDR_W-1:0] idx);
      return strobe && (a == idx);
   endfunction : wr_sel

   // register decode
   wire wr_ctrl = wr_sel(WR, ADDR, addr_filter_pkg::REG_CTRL);
   wire wr_slave_address = wr_sel(WR, ADDR, addr_filter_pkg::REG_SLAVE_ADDRESS);
   wire wr_smask = wr_sel(WR, ADDR, addr_filter_pkg::REG_SMASK);
   wire wr_clr = wr_sel(WR, ADDR, addr_filter_pkg::REG_CLR);
   wire wr_ien = wr_sel(WR, ADDR, addr_filter_pkg::REG_IEN);
   wire mpe = ctrl_r[addr_filter_pkg::CTRL_MPE];
   assign mode = addr_filter_pkg::frame_mode_t'(
      ctrl_r[addr_filter_pkg::CTRL_MODE_HI:addr_filter_pkg::CTRL_MODE_LO]);

   // comparator sees the eight data bits at the stop-bit sample
   assign m.rx_byte = FRAME_DATA;
   assign m.slave_address = slave_address_r;
   assign m.slave_address_mask = smask_r;
   addr_compare u_cmp (.m(m));

   // frame classification
   // the compare runs every cycle; only FRAME_DONE gives its answer any weight
   wire nine_bit_mode = mode == addr_filter_pkg::MODE2 || mode == addr_filter_pkg::MODE3;
   wire is_addr = FRAME_BIT9;
   wire addr_hit = m.given_hit || m.bcast_hit;
   logic pass;
   always_comb begin
      unique case (mode)
         addr_filter_pkg::MODE0: pass = 1'b1;
         addr_filter_pkg::MODE1: pass = !mpe || FRAME_STOP_OK;
         addr_filter_pkg::MODE2,
         addr_filter_pkg::MODE3: pass = !mpe || (is_addr && addr_hit);
      endcase
   end
   wire accept = FRAME_DONE && pass;
   wire drop = FRAME_DONE && !pass;
   wire fe_evt = FRAME_DONE && !FRAME_STOP_OK;

   // status: set wins over clear in the same cycle
   // clear is applied first so an event in the clear cycle is never lost
   always_comb begin
      stat_nxt = stat_r;
      if (wr_clr) begin
         stat_nxt = stat_r & ~WDATA[addr_filter_pkg::ST_W-1:0];
      end
      if (accept) begin
         stat_nxt[addr_filter_pkg::ST_RX] = 1'b1;
      end
      if (fe_evt) begin
         stat_nxt[addr_filter_pkg::ST_FE] = 1'b1;
      end
      if (drop) begin
         stat_nxt[addr_filter_pkg::ST_DROP] = 1'b1;
      end
   end

   // read mux, unmapped reads return zero
   // the registered read keeps the answer at exactly one cycle after the strobe
   always_comb begin
      rdata_nxt = '0;
      unique case (ADDR)
         addr_filter_pkg::REG_CTRL: rdata_nxt[CW-1:0] = ctrl_r;
         addr_filter_pkg::REG_SLAVE_ADDRESS: rdata_nxt = slave_address_r;
         addr_filter_pkg::REG_SMASK: rdata_nxt = smask_r;
         addr_filter_pkg::REG_STAT: rdata_nxt[addr_filter_pkg::ST_W-1:0] = stat_r;
         addr_filter_pkg::REG_IEN: rdata_nxt[addr_filter_pkg::ST_W-1:0] = ien_r;
         addr_filter_pkg::REG_RXDATA: rdata_nxt = rxbyte_r;
         default: rdata_nxt = '0;
      endcase
   end

   // software registers
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         ctrl_r <= addr_filter_pkg::CTRL_RST;
         slave_address_r <= addr_filter_pkg::SLAVE_ADDRESS_RST;
         smask_r <= addr_filter_pkg::SMASK_RST;
         ien_r <= '0;
      end else if (CE) begin
         if (wr_ctrl) ctrl_r <= WDATA[CW-1:0];
         if (wr_slave_address) slave_address_r <= WDATA;
         if (wr_smask) smask_r <= WDATA;
         if (wr_ien) ien_r <= WDATA[addr_filter_pkg::ST_W-1:0];
      end
   end

   // status, read data and interrupt
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         stat_r <= '0;
         rdata_r <= '0;
         irq_r <= 1'b0;
      end else if (CE) begin
         stat_r <= stat_nxt;
         rdata_r <= RD ? rdata_nxt : '0;
         irq_r <= |(stat_nxt & ien_r);
      end
   end

   // accepted frame outputs; ninth bit latched on every 9-bit frame
   // the byte moves only on accept, so a refused frame cannot overwrite it
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         accept_r <= 1'b0;
         ninth_r <= 1'b0;
         rxbyte_r <= '0;
      end else if (CE) begin
         accept_r <= accept;
         if (BIT9_VALID && nine_bit_mode) ninth_r <= FRAME_BIT9;
         if (accept) rxbyte_r <= FRAME_DATA;
      end
   end

   assign RDATA = rdata_r;
   assign RX_ACCEPT = accept_r;
   assign RX_BYTE = rxbyte_r;
   assign NINTH_RX_BIT = ninth_r;
   assign MULTIPROC_ENABLE = ctrl_r[addr_filter_pkg::CTRL_MPE];
   assign IRQ = irq_r;

   // data byte never accepted while enable set in nine-bit modes
   a_data_suppress: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && !FRAME_BIT9 && mpe && nine_bit_mode |=> !RX_ACCEPT)
      else $error("data byte accepted while filtering");
   // matching address accepted in nine-bit modes
   a_addr_accept: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && FRAME_BIT9 && nine_bit_mode && addr_hit |=> RX_ACCEPT)
      else $error("matching address not accepted");
   // mode 0 always accepts
   a_mode0_pass: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && mode == addr_filter_pkg::MODE0
      |=> RX_ACCEPT && stat_r[addr_filter_pkg::ST_RX])
      else $error("mode 0 frame dropped");
   // mode 1 bad stop dropped under enable
   a_mode1_stop: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && mode == addr_filter_pkg::MODE1 && mpe && !FRAME_STOP_OK
      |=> !RX_ACCEPT)
      else $error("mode 1 bad stop accepted");
   // given match on exact address whatever the mask
   a_given_exact: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      m.rx_byte == m.slave_address |-> m.given_hit)
      else $error("given address missed");
   // broadcast with all ones
   a_bcast_ones: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      m.rx_byte == 8'hff |-> m.bcast_hit)
      else $error("all-ones broadcast missed");
   // ninth bit stored in nine-bit modes
   a_ninth_store: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && BIT9_VALID && nine_bit_mode |=> NINTH_RX_BIT == $past(FRAME_BIT9))
      else $error("ninth bit not stored");
   // reset clears address registers
   a_reset_clear: assert property (@(posedge CLK_SYS)
      !RST_N |=> slave_address_r == 8'h00 && smask_r == 8'h00)
      else $error("address not cleared at reset");
   // checks of the filter, registers and reset; all but a_reset_clear and a_reset_out are disabled while reset is low
   // an unmatched address under the enable leaves the accept strobe low
   a_refuse_quiet: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && FRAME_BIT9 && nine_bit_mode && mpe && !addr_hit
      |=> !RX_ACCEPT)
      else $error("unmatched address accepted");
   // refused frames are still recorded in the dropped flag
   a_drop_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && !pass |=> stat_r[addr_filter_pkg::ST_DROP] && !RX_ACCEPT)
      else $error("refused frame not flagged");
   // without the enable nothing is filtered in any mode
   a_enable_off: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && !mpe |=> RX_ACCEPT)
      else $error("frame filtered with enable clear");
   // mode 1 frame with a good stop bit passes
   a_mode1_good: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && mode == addr_filter_pkg::MODE1 && FRAME_STOP_OK |=> RX_ACCEPT)
      else $error("mode 1 good stop dropped");
   // a bad stop bit is flagged whatever the mode
   a_stop_error: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && FRAME_DONE && !FRAME_STOP_OK |=> stat_r[addr_filter_pkg::ST_FE])
      else $error("bad stop not flagged");
   // the accepted byte is the eight data bits of that frame
   a_byte_capture: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && accept |=> RX_BYTE == $past(FRAME_DATA) && stat_r[addr_filter_pkg::ST_RX])
      else $error("accepted byte not captured");
   // no accept, no change of the stored byte
   a_byte_keep: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && !accept |=> $stable(RX_BYTE))
      else $error("stored byte changed without accept");
   // without a ninth-bit strobe the stored bit holds
   a_ninth_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && !BIT9_VALID |=> $stable(NINTH_RX_BIT))
      else $error("ninth bit changed without strobe");
   // eight-bit modes leave the stored ninth bit untouched
   a_mode0_ninth: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && !nine_bit_mode |=> $stable(NINTH_RX_BIT))
      else $error("ninth bit stored outside nine-bit modes");
   // the enable output follows a control write
   a_enable_copy: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && wr_ctrl |=> MULTIPROC_ENABLE == $past(WDATA[addr_filter_pkg::CTRL_MPE]))
      else $error("enable bit not written");
   // cleared address registers make every byte a given and a broadcast match
   a_open_filter: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      m.slave_address == 8'h00 && m.slave_address_mask == 8'h00
      |-> m.given_hit && m.bcast_hit)
      else $error("cleared filter refused a byte");
   // a byte with none of the broadcast ones set is no broadcast hit
   a_bcast_need: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (m.slave_address | m.slave_address_mask) != 8'h00
      && m.rx_byte == ~(m.slave_address | m.slave_address_mask) |-> !m.bcast_hit)
      else $error("broadcast hit without its ones");
   // a difference in a masked bit refuses the given address
   a_given_miss: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (m.rx_byte & m.slave_address_mask) != (m.slave_address & m.slave_address_mask)
      |-> !m.given_hit)
      else $error("given address hit on a masked difference");
   // interrupt is the level of the enabled sticky flags
   a_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && !wr_ien |=> IRQ == |(stat_r & ien_r))
      else $error("interrupt level wrong");
   // read data stand only in the cycle after the strobe
   a_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && !RD |=> RDATA == '0)
      else $error("read data outside read cycle");
   // a slave address read returns the register one cycle later
   a_read_slave_address: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && RD && ADDR == addr_filter_pkg::REG_SLAVE_ADDRESS |=> RDATA == $past(slave_address_r))
      else $error("slave address read wrong");
   // status reads return the flags with the upper bits zero
   a_read_stat: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && RD && ADDR == addr_filter_pkg::REG_STAT
      |=> RDATA == DW'($past(stat_r)))
      else $error("status read wrong");
   // the accept strobe only follows a finished frame
   a_rx_pulse: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && !FRAME_DONE |=> !RX_ACCEPT)
      else $error("accept without a frame");
   // writes land in the address registers one cycle later
   a_slave_address_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && wr_slave_address |=> slave_address_r == $past(WDATA))
      else $error("slave address write lost");
   a_smask_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && wr_smask |=> smask_r == $past(WDATA))
      else $error("address mask write lost");
   // clock enable low freezes the registers and the interrupt
   a_ce_freeze: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !CE |=> $stable(ctrl_r) && $stable(slave_address_r) && $stable(stat_r) && $stable(IRQ))
      else $error("state moved with clock enable low");
   // reset leaves every output low and the control at its reset value
   a_reset_out: assert property (@(posedge CLK_SYS)
      !RST_N |=> !RX_ACCEPT && !IRQ && !NINTH_RX_BIT && RDATA == '0 && RX_BYTE == '0
      && ctrl_r == addr_filter_pkg::CTRL_RST)
      else $error("outputs not cleared at reset");
endmodule : uart_multidrop_address_filter

// ==== verif/frame_master_model.sv ====
// Purpose: deframer side that hands finished frames to the filter
// Assumes: one frame at a time, driven just after rising edges
// Notes: released lines show the inverse of the last frame
`timescale 1ns/100ps
module frame_master_model (
   input wire logic clk,
   output logic bit9_valid,
   output logic [7:0] data,
   output logic bit9,
   output logic done,
   output logic stop_ok
);
   initial begin
      bit9_valid = 1'b0;
      done = 1'b0;
      data = 8'h00;
      bit9 = 1'b0;
      stop_ok = 1'b0;
   end
   // ninth bit is handed over before the stop sample
   task automatic send(input logic [7:0] d, input logic b9, input logic s);
      @(posedge clk);
      bit9_valid <= 1'b1;
      bit9 <= b9;
      @(posedge clk);
      bit9_valid <= 1'b0;
      done <= 1'b1;
      data <= d;
      stop_ok <= s;
      @(posedge clk);
      done <= 1'b0;
      // stale values must not pass for a frame, so invert them
      data <= ~d;
      bit9 <= ~b9;
      stop_ok <= ~s;
   endtask : send
endmodule : frame_master_model

// ==== verif/uart_multidrop_address_filter_tb_top.sv ====
// Purpose: self-checking bench of the multidrop receive filter
// Assumes: clock enable low only inside the freeze scenario
// Notes: a data frame is also sent ahead of its address frame to show it is refused
`timescale 1ns/100ps
module uart_multidrop_address_filter_tb_top;
   logic clk_sys, rst_n, wr, rd, bv, b9, dn, so, acc, nb, mpe, irq, ce;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, fd, rxb;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   uart_multidrop_address_filter u_uart_multidrop_address_filter (.CLK_SYS(clk_sys),
      .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .BIT9_VALID(bv), .FRAME_DATA(fd), .FRAME_BIT9(b9), .FRAME_DONE(dn),
      .FRAME_STOP_OK(so), .RX_ACCEPT(acc), .RX_BYTE(rxb), .NINTH_RX_BIT(nb),
      .MULTIPROC_ENABLE(mpe), .IRQ(irq));
   frame_master_model u_frame_master_model (.clk(clk_sys), .bit9_valid(bv), .data(fd),
      .bit9(b9), .done(dn), .stop_ok(so));
   task automatic conclude();
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wreg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wreg
   // read data stand only in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 chk_val(rdata, exp);
   endtask : rreg
   task automatic frm(input logic [7:0] v, input logic n, input logic s, input logic exp);
      u_frame_master_model.send(v, n, s);
      #1 chk_bit(acc, exp);
      if (exp) chk_val(rxb, v);
   endtask : frm
   task automatic t_reset();
      rreg(addr_filter_pkg::REG_SLAVE_ADDRESS, 8'h00);
      rreg(addr_filter_pkg::REG_SMASK, 8'h00);
      rreg(4'hf, 8'h00);
      wreg(addr_filter_pkg::REG_CTRL, 8'h05);
      #1 chk_bit(mpe, 1'b1);
      frm(8'h5a, 1'b1, 1'b1, 1'b1);
   endtask : t_reset
   task automatic t_filter();
      wreg(addr_filter_pkg::REG_CTRL, 8'h01);
      frm(8'h33, 1'b0, 1'b1, 1'b1);
      wreg(addr_filter_pkg::REG_SLAVE_ADDRESS, 8'hc0);
      wreg(addr_filter_pkg::REG_SMASK, 8'hfd);
      wreg(addr_filter_pkg::REG_CTRL, 8'h07);
      frm(8'hc2, 1'b0, 1'b1, 1'b0);
      frm(8'hc2, 1'b1, 1'b1, 1'b1);
      chk_bit(nb, 1'b1);
      frm(8'hc1, 1'b1, 1'b1, 1'b0);
      frm(8'hfd, 1'b1, 1'b1, 1'b1);
      frm(8'h7d, 1'b1, 1'b1, 1'b0);
      wreg(addr_filter_pkg::REG_CTRL, 8'h04);
      frm(8'h11, 1'b0, 1'b1, 1'b1);
      chk_bit(nb, 1'b0);
      wreg(addr_filter_pkg::REG_CTRL, 8'h03);
      frm(8'h44, 1'b0, 1'b0, 1'b0);
      frm(8'h44, 1'b0, 1'b1, 1'b1);
   endtask : t_filter
   // sticky status, enable mask and write-one clear
   task automatic t_irq();
      rreg(addr_filter_pkg::REG_STAT, 8'h07);
      chk_bit(irq, 1'b0);
      wreg(addr_filter_pkg::REG_IEN, 8'h01);
      rreg(addr_filter_pkg::REG_IEN, 8'h01);
      chk_bit(irq, 1'b1);
      wreg(addr_filter_pkg::REG_CLR, 8'h01);
      rreg(addr_filter_pkg::REG_STAT, 8'h06);
      chk_bit(irq, 1'b0);
      wreg(addr_filter_pkg::REG_IEN, 8'h04);
      rreg(addr_filter_pkg::REG_IEN, 8'h04);
      chk_bit(irq, 1'b1);
      wreg(addr_filter_pkg::REG_CLR, 8'h07);
      rreg(addr_filter_pkg::REG_STAT, 8'h00);
      chk_bit(irq, 1'b0);
   endtask : t_irq
   // a write while clock enable is low must be lost; read data drop to zero after
   task automatic t_freeze();
      @(posedge clk_sys);
      ce <= 1'b0;
      addr <= addr_filter_pkg::REG_SLAVE_ADDRESS;
      wdata <= 8'h5a;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      ce <= 1'b1;
      rreg(addr_filter_pkg::REG_SLAVE_ADDRESS, 8'hc0);
      rreg(addr_filter_pkg::REG_CTRL, 8'h03);
      rreg(addr_filter_pkg::REG_RXDATA, 8'h44);
      @(posedge clk_sys);
      #1 chk_val(rdata, 8'h00);
   endtask : t_freeze
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // a hang must still reach the verdict
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_filter();
      t_irq();
      t_freeze();
      conclude();
   end
endmodule : uart_multidrop_address_filter_tb_top
